// ---- hdl/anpage_defines.vh ----
`ifndef ANPAGE_DEFINES_VH
`define ANPAGE_DEFINES_VH

// Management register addresses within one port
`define REG_PARTNER_PAGE 5'h05
`define REG_AUTONEG_EXPANSION 5'h06
`define REG_NEXT_PAGE_TRANSMIT 5'h07

// Reset values
`define PARTNER_PAGE_RESET 16'h0000
`define NEXT_PAGE_TRANSMIT_RESET 16'h2001

// Code word field positions (shared by partner page and transmit page)
`define PG_NEXT_PAGE 15
`define PG_ACK 14
`define PG_REMOTE_FAULT 13
`define PG_MESSAGE_PAGE 13
`define PG_ACK2 12
`define PG_TOGGLE 11
`define PG_MSG_HI 10
`define PG_MSG_LO 0

// Expansion register field positions
`define EXP_PARTNER_AN_ABLE 0
`define EXP_PAGE_RECEIVED 1
`define EXP_NEXT_PAGE_ABLE 2
`define EXP_PARTNER_NP_ABLE 3

// Port count and port select width
`define NUM_PORTS 4
`define PORT_W 2

`endif

// ---- hdl/toggle_tracker.v ----
`timescale 1ns/1ps
`include "anpage_defines.vh"

// Keeps the toggle bit of the next page a port will send.
module toggle_tracker (
   input wire i_clk,
   input wire i_reset,
   input wire i_base_sent,
   input wire i_base_toggle,
   input wire i_next_sent,
   output reg o_toggle
);

   always @(posedge i_clk) begin
      if (i_reset) begin
         o_toggle <= 1'b0;
      end else if (i_base_sent) begin
         // First next page carries the inverse of the base page's bit 11
         o_toggle <= ~i_base_toggle; // [RULE12]
      end else if (i_next_sent) begin
         o_toggle <= ~o_toggle; // [RULE12]
      end
   end

endmodule

// ---- hdl/autoneg_page_registers.v ----
`timescale 1ns/1ps
`include "anpage_defines.vh"

// How it works
// RULE1 - Partner page register is read-only, latest word
// RULE2 - Base page: NP, ACK, RF, ability, selector
// RULE3 - Next page: NP, ACK, MP, ACK2, toggle, message
// RULE4 - Page received bit sets, clears on read
// RULE5 - Next page able reads one, upper bits zero
// RULE6 - Partner NP able and AN able, read-only
// RULE7 - Transmit next page resets to 0x2001
// RULE8 - Writable NP, MP, ACK2, message; toggle RO
// RULE9 - Independent register copies for every port
// RULE10 - Advertised next-page bit requests page exchange
// RULE11 - Controller restarts autoneg after advertisement change; here no restart, o_np_request only follows i_adv_next_page
// RULE12 - Transmit toggle alternates, starts inverted from base
module autoneg_page_registers (
   input wire i_clk,
   input wire i_reset,
   // Management access, already deserialised by the MII management engine
   input wire i_mgmt_rd,
   input wire i_mgmt_wr,
   input wire [1:0] i_mgmt_port,
   input wire [4:0] i_mgmt_addr,
   input wire [15:0] i_mgmt_wdata,
   output reg [15:0] o_mgmt_rdata,
   output reg o_mgmt_rvalid,
   // Line-side arbitration events, one bit or word per port
   input wire [3:0] i_page_rx,
   input wire [63:0] i_page_rx_word,
   input wire [3:0] i_partner_an_able,
   input wire [3:0] i_partner_np_able,
   input wire [3:0] i_adv_next_page,
   input wire [3:0] i_base_sent,
   input wire [3:0] i_base_toggle,
   input wire [3:0] i_next_sent,
   // Per-port results
   output reg [63:0] o_partner_page,
   output reg [63:0] o_tx_next_page,
   output reg [3:0] o_page_alert,
   output reg [3:0] o_np_request
);

   wire [3:0] port_toggle;
   reg [3:0] exp_an_able_q;
   reg [3:0] exp_np_able_q;
   reg [3:0] page_rcvd_q;
   reg [15:0] tx_word_q [0:3];
   reg [15:0] rdata_d;
   reg [15:0] exp_word;

   genvar gp;
   generate
      for (gp = 0; gp < `NUM_PORTS; gp = gp + 1) begin : g_port
         wire sel;
         wire rd_exp;
         wire wr_tx;
         assign sel = (i_mgmt_port == gp[1:0]); // [RULE9]
         assign rd_exp = i_mgmt_rd && sel && (i_mgmt_addr == `REG_AUTONEG_EXPANSION);
         assign wr_tx = i_mgmt_wr && sel && (i_mgmt_addr == `REG_NEXT_PAGE_TRANSMIT);

         // Partner page takes the whole received word; its layout is the
         // partner's, base or next page, and is not reinterpreted here.
         always @(posedge i_clk) begin
            if (i_reset) begin
               o_partner_page[gp*16 +: 16] <= `PARTNER_PAGE_RESET; // [RULE2] [RULE3]
            end else if (i_page_rx[gp]) begin
               o_partner_page[gp*16 +: 16] <= i_page_rx_word[gp*16 +: 16]; // [RULE1]
            end
         end

         // A new page arriving in the cycle of a read keeps the flag set
         always @(posedge i_clk) begin
            if (i_reset) begin
               page_rcvd_q[gp] <= 1'b0;
            end else if (i_page_rx[gp]) begin
               page_rcvd_q[gp] <= 1'b1; // [RULE4]
            end else if (rd_exp) begin
               page_rcvd_q[gp] <= 1'b0; // [RULE4]
            end
         end

         always @(posedge i_clk) begin
            if (i_reset) begin
               exp_an_able_q[gp] <= 1'b0;
               exp_np_able_q[gp] <= 1'b0;
            end else begin
               exp_an_able_q[gp] <= i_partner_an_able[gp]; // [RULE6]
               exp_np_able_q[gp] <= i_partner_np_able[gp]; // [RULE6]
            end
         end

         // Bit 14 is never stored as one; toggle comes from the tracker
         always @(posedge i_clk) begin
            if (i_reset) begin
               tx_word_q[gp] <= `NEXT_PAGE_TRANSMIT_RESET; // [RULE7]
            end else if (wr_tx) begin
               tx_word_q[gp] <= {i_mgmt_wdata[`PG_NEXT_PAGE], 1'b0,
                                 i_mgmt_wdata[`PG_MESSAGE_PAGE],
                                 i_mgmt_wdata[`PG_ACK2], 1'b0,
                                 i_mgmt_wdata[`PG_MSG_HI:`PG_MSG_LO]}; // [RULE8]
            end
         end

         toggle_tracker u_toggle (
            .i_clk(i_clk),
            .i_reset(i_reset),
            .i_base_sent(i_base_sent[gp]),
            .i_base_toggle(i_base_toggle[gp]),
            .i_next_sent(i_next_sent[gp]),
            .o_toggle(port_toggle[gp])
         );

         always @(posedge i_clk) begin
            if (i_reset) begin
               o_tx_next_page[gp*16 +: 16] <= `NEXT_PAGE_TRANSMIT_RESET;
               o_page_alert[gp] <= 1'b0;
               o_np_request[gp] <= 1'b0;
            end else begin
               o_tx_next_page[gp*16 +: 16] <= {tx_word_q[gp][15:12], port_toggle[gp],
                                               tx_word_q[gp][10:0]}; // [RULE12]
               o_page_alert[gp] <= page_rcvd_q[gp];
               // Follows the advertised bit one cycle later, with no restart of autoneg
               o_np_request[gp] <= i_adv_next_page[gp]; // [RULE10] [RULE11]
            end
         end
      end
   endgenerate

   // Read mux; unmapped addresses read as zero so the engine can own them
   always @* begin
      exp_word = 16'h0000; // [RULE5]
      exp_word[`EXP_PARTNER_AN_ABLE] = exp_an_able_q[i_mgmt_port];
      exp_word[`EXP_PAGE_RECEIVED] = page_rcvd_q[i_mgmt_port];
      exp_word[`EXP_NEXT_PAGE_ABLE] = 1'b1; // [RULE5]
      exp_word[`EXP_PARTNER_NP_ABLE] = exp_np_able_q[i_mgmt_port];
      case (i_mgmt_addr)
         `REG_PARTNER_PAGE: begin
            rdata_d = o_partner_page[i_mgmt_port*16 +: 16]; // [RULE1]
         end
         `REG_AUTONEG_EXPANSION: begin
            rdata_d = exp_word; // [RULE6]
         end
         `REG_NEXT_PAGE_TRANSMIT: begin
            rdata_d = {tx_word_q[i_mgmt_port][15:12], port_toggle[i_mgmt_port],
                       tx_word_q[i_mgmt_port][10:0]}; // [RULE8]
         end
         default: begin
            rdata_d = 16'h0000;
         end
      endcase
   end

   always @(posedge i_clk) begin
      if (i_reset) begin
         o_mgmt_rdata <= 16'h0000;
         o_mgmt_rvalid <= 1'b0;
      end else begin
         o_mgmt_rvalid <= i_mgmt_rd;
         if (i_mgmt_rd) begin
            o_mgmt_rdata <= rdata_d;
         end
      end
   end

endmodule

// ---- tb/anpage_checker.sv ----
`timescale 1ns/1ps
module anpage_checker (
   input wire i_clk,
   input wire i_reset,
   input wire i_mgmt_rd,
   input wire [1:0] i_mgmt_port,
   input wire [4:0] i_mgmt_addr,
   input wire [15:0] o_mgmt_rdata,
   input wire o_mgmt_rvalid,
   input wire [3:0] i_page_rx,
   input wire [63:0] i_page_rx_word,
   input wire [63:0] o_partner_page,
   input wire [3:0] o_page_alert,
   input wire [3:0] i_adv_next_page,
   input wire [3:0] o_np_request
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   sequence s_rd(a);
      i_mgmt_rd && i_mgmt_addr == a;
   endsequence
   a_read_answer: assert property (i_mgmt_rd |=> o_mgmt_rvalid)
      else $error("read without answer");
   a_no_answer: assert property (!i_mgmt_rd |=> !o_mgmt_rvalid)
      else $error("answer without read");
   a_page_store: assert property (i_page_rx[0] |=> o_partner_page[15:0] == $past(i_page_rx_word[15:0]))
      else $error("page word not stored");
   a_page_hold: assert property (!i_page_rx[0] |=> $stable(o_partner_page[15:0]))
      else $error("page word changed");
   a_exp_fixed: assert property (s_rd(5'h06) |=> o_mgmt_rdata[15:4] == 12'h000 && o_mgmt_rdata[2])
      else $error("expansion fixed bits");
   a_alert_set: assert property (i_page_rx[0] |=> ##1 o_page_alert[0])
      else $error("page flag not set");
   a_alert_clear: assert property (i_mgmt_rd && i_mgmt_addr == 5'h06 && i_mgmt_port == 2'h0
      && !i_page_rx[0] |=> ##1 !o_page_alert[0])
      else $error("page flag not cleared");
   a_np_follow: assert property (!$past(i_reset) |-> o_np_request == $past(i_adv_next_page))
      else $error("next page request lag");
   a_tx_rsvd: assert property (s_rd(5'h07) |=> !o_mgmt_rdata[14])
      else $error("transmit bit 14 set");
endmodule
bind autoneg_page_registers anpage_checker chk (.i_clk, .i_reset, .i_mgmt_rd, .i_mgmt_port,
   .i_mgmt_addr, .o_mgmt_rdata, .o_mgmt_rvalid, .i_page_rx, .i_page_rx_word, .o_partner_page,
   .o_page_alert, .i_adv_next_page, .o_np_request);

// ---- tb/mgmt_ctl.sv ----
`timescale 1ns/1ps
module mgmt_ctl (
   input wire i_clk,
   input wire [15:0] i_rdata,
   input wire i_rvalid,
   output reg o_rd = 1'b0,
   output reg o_wr = 1'b0,
   output reg [1:0] o_port = 2'h0,
   output reg [4:0] o_addr = 5'h00,
   output reg [15:0] o_wdata = 16'h0000
);
   // Strobes last one cycle; write data is inverted after use so stale values never match
   task wr(input [1:0] p, input [4:0] a, input [15:0] d);
      @(posedge i_clk) #1 {o_wr, o_port, o_addr, o_wdata} = {1'b1, p, a, d};
      @(posedge i_clk) #1 o_wr = 1'b0;
      o_wdata = ~d;
   endtask
   task rd(input [1:0] p, input [4:0] a, output [15:0] d);
      @(posedge i_clk) #1 {o_rd, o_port, o_addr} = {1'b1, p, a};
      @(posedge i_clk) #1 o_rd = 1'b0;
      d = i_rvalid ? i_rdata : 16'hxxxx;
   endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   reg i_clk = 1'b0;
   reg i_reset = 1'b1;
   reg [3:0] rx = 4'h0, an = 4'h0, np = 4'h0, adv = 4'h0, bs = 4'h0, ns = 4'h0;
   reg [63:0] word = 64'h0;
   reg [3:0] bt = 4'h0;
   wire [63:0] tx_np;
   wire [3:0] npr;
   reg [15:0] v;
   wire rd, wr, rvalid;
   wire [1:0] port;
   wire [4:0] addr;
   wire [15:0] wdata, rdata;
   integer mismatches = 0, num_checks = 0, cyc = 0, i;
   initial forever #12.5 i_clk = ~i_clk;
   mgmt_ctl ctl (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_rd(rd), .o_wr(wr),
      .o_port(port), .o_addr(addr), .o_wdata(wdata));
   autoneg_page_registers uut (.i_clk(i_clk), .i_reset(i_reset), .i_mgmt_rd(rd), .i_mgmt_wr(wr),
      .i_mgmt_port(port), .i_mgmt_addr(addr), .i_mgmt_wdata(wdata), .o_mgmt_rdata(rdata),
      .o_mgmt_rvalid(rvalid), .i_page_rx(rx), .i_page_rx_word(word), .i_partner_an_able(an),
      .i_partner_np_able(np), .i_adv_next_page(adv), .i_base_sent(bs), .i_base_toggle(bt),
      .i_next_sent(ns), .o_partner_page(), .o_tx_next_page(tx_np), .o_page_alert(),
      .o_np_request(npr));
   task cmpv(input [15:0] e, input [15:0] s);
      num_checks = num_checks + 1;
      if (s !== e) begin
         mismatches = mismatches + 1;
         $display("Error output expected %h seen %h", e, s);
      end
   endtask
   task chk(input [1:0] p, input [4:0] a, input [15:0] e);
      ctl.rd(p, a, v);
      num_checks = num_checks + 1;
      if (v !== e) begin
         mismatches = mismatches + 1;
         $display("Error reg %0d port %0d expected %h seen %h", a, p, e, v);
      end
   endtask
   task strobe(input integer k, input [1:0] p);
      @(posedge i_clk) #1;
      case (k)
         0: rx[p] = 1'b1;
         1: bs[p] = 1'b1;
         default: ns[p] = 1'b1;
      endcase
      @(posedge i_clk) #1 {rx, bs, ns} = 12'h000;
   endtask
   task t_reset;
      for (i = 0; i < 4; i = i + 1) begin
         chk(i, 5'h05, 16'h0000);
         chk(i, 5'h06, 16'h0004);
         chk(i, 5'h07, 16'h2001);
      end
   endtask
   task t_page;
      for (i = 0; i < 4; i = i + 1) begin
         word[16 * i +: 16] = (i % 2) ? 16'h7abc : 16'h8421;
         strobe(0, i);
         chk(i, 5'h05, word[16 * i +: 16]);
         if (i < 3) chk(i + 1, 5'h06, 16'h0004);
         chk(i, 5'h06, 16'h0006);
         chk(i, 5'h06, 16'h0004);
      end
      ctl.wr(0, 5'h05, 16'hffff);
      chk(0, 5'h05, 16'h8421);
   endtask
   task t_write;
      ctl.wr(1, 5'h07, 16'hffff);
      chk(1, 5'h07, 16'hb7ff);
      chk(2, 5'h07, 16'h2001);
      ctl.wr(1, 5'h07, 16'h0000);
      chk(1, 5'h07, 16'h0000);
      ctl.wr(1, 5'h06, 16'hffff);
      chk(1, 5'h06, 16'h0004);
      ctl.wr(1, 5'h1f, 16'hffff);
      chk(1, 5'h1f, 16'h0000);
   endtask
   task t_toggle;
      strobe(1, 2);
      chk(2, 5'h07, 16'h2801);
      cmpv(16'h2801, tx_np[47:32]);
      strobe(2, 2);
      chk(2, 5'h07, 16'h2001);
      cmpv(16'h2001, tx_np[47:32]);
      bt = 4'h4;
      strobe(1, 2);
      chk(2, 5'h07, 16'h2001);
      strobe(2, 2);
      chk(2, 5'h07, 16'h2801);
      cmpv(16'h2801, tx_np[47:32]);
   endtask
   task t_cap;
      #1 {an, np, adv} = 12'h885;
      chk(3, 5'h06, 16'h000d);
      chk(2, 5'h06, 16'h0004);
      cmpv(16'h0005, {12'h000, npr});
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge i_clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         mismatches = mismatches + 1;
         finish_test;
      end
   end
   initial begin
      repeat (8) @(posedge i_clk);
      #1 i_reset = 1'b0;
      t_reset;
      t_page;
      t_write;
      t_toggle;
      t_cap;
      finish_test;
   end
endmodule
